// ---- hw/contact_io_pkg.sv ----
// Constants and carrier types for the contact input/output control block
package contact_io_pkg;
   // Debounce time and derived cycle count at 100 MHz
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned DEBOUNCE_TIME_US = 20;
   localparam int unsigned DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
   localparam int unsigned DB_CNT_W         = 11;
   localparam logic [10:0] DB_CNT_LAST      = 11'(DEBOUNCE_CYCLES - 1);
   // Contact input positions
   localparam int unsigned NUM_DI           = 8;
   localparam int unsigned DI_SEL0          = 0;
   localparam int unsigned DI_RUN           = 4;
   localparam int unsigned DI_STOP          = 5;
   localparam int unsigned DI_PVSRC         = 6;
   localparam int unsigned DI_OFFSET        = 7;
   // Pattern numbering
   localparam logic [4:0]  PATTERN_OFFSET   = 5'h10;
   localparam logic [4:0]  PATTERN_RESET    = 5'h01;
   // Parameter codes
   localparam logic [1:0]  SWITCH_CONTACT   = 2'h2;
   localparam logic [2:0]  RET_LOOP_POWER   = 3'h4;
   localparam logic [2:0]  RET_SRC_PV       = 3'h1;
   localparam logic [2:0]  RET_SRC_SP       = 3'h2;
   localparam logic [2:0]  RET_SRC_OUT      = 3'h3;
   localparam int unsigned NUM_PID_GROUPS   = 8;
   localparam int unsigned DATA_W           = 16;
   localparam logic [15:0] DATA_RESET       = 16'h0000;

   typedef enum logic [1:0] {OUT_CURRENT, OUT_PULSE, OUT_RELAY, OUT_RSVD} out_type_t;

   // Contact outputs in descending order
   typedef struct packed {
      logic [3:0] time_event;
      logic       alarm;
      logic       pv_event2;
      logic       pv_event1;
   } contact_out_t;

   // Analog values offered for routing
   typedef struct packed {
      logic [15:0] pv;
      logic [15:0] setpoint;
      logic [15:0] control;
   } analog_src_t;
endpackage : contact_io_pkg

// ---- hw/contact_io_mode_control.sv ----
// Contact input decode, run/stop control and contact/analog output routing
// Notes on behaviour
// [RULE1] Four select contacts form binary pattern number
// [RULE2] Pattern changes accepted only in reset mode
// [RULE3] Offset contact adds sixteen to pattern
// [RULE4] Run contact rising edge starts program
// [RULE5] Stop contact rising edge halts program
// [RULE6] Halted output equals preset output value
// [RULE7] Preset output overrides manual output when halted
// [RULE8] Source contact switches PV only in method 2
// [RULE9] Contact off selects input 1, on input 2
// [RULE10] Eight parameter groups, active one is used
// [RULE11] PV events drive first two contact outputs
// [RULE12] Alarm one drives third contact output
// [RULE13] Time events drive outputs four to seven
// [RULE14] Control output type current, pulse or relay
// [RULE15] First retransmission source chosen by type
// [RULE16] Second retransmission only with relay output
// [RULE17] Loop power excludes retransmission on terminal
// [RULE18] Type code 4 enables loop power
// [RULE19] Contacts debounced before single edge events
`timescale 1ns/100ps
`default_nettype none
module contact_io_mode_control
(
   // Clock and reset
   input  wire  logic                        REF_CLK,
   input  wire  logic                        RESETN,
   // Contact inputs: select bits 0..3, run, stop, PV source, offset
   input  wire  logic [7:0]                  CONTACT_IN,
   // Configuration
   input  wire  logic [1:0]                  SWITCH_METHOD_SELECT,
   input  wire  logic [1:0]                  CONTROL_OUTPUT_TYPE,
   input  wire  logic [2:0]                  AUX_ANALOG_OUT_A_TYPE,
   input  wire  logic [2:0]                  AUX_ANALOG_OUT_B_TYPE,
   input  wire  logic [15:0]                 PRESET_OUTPUT_VALUE,
   input  wire  logic [2:0]                  PID_GROUP_SEL,
   input  wire  logic [15:0]                 PID_GROUP_PARAM [8],
   // Process values and events
   input  wire  logic [15:0]                 PV_INPUT1,
   input  wire  logic [15:0]                 PV_INPUT2,
   input  wire  logic                        PV_AUTO_SEL2,
   input  wire  contact_io_pkg::analog_src_t ANALOG_SRC,
   input  wire  logic                        MANUAL_MODE,
   input  wire  logic [15:0]                 MANUAL_OUTPUT_VALUE,
   input  wire  logic                        KEY_STOP,
   input  wire  logic                        PV_EVENT1,
   input  wire  logic                        PV_EVENT2,
   input  wire  logic                        ALARM1,
   input  wire  logic [3:0]                  TIME_EVENT,
   // Status and outputs
   output logic [4:0]                        PATTERN_NUMBER,
   output logic                              RUNNING,
   output logic                              START_PULSE,
   output logic                              STOP_PULSE,
   output logic [15:0]                       PV_SELECTED,
   output logic [15:0]                       ACTIVE_PID_PARAM,
   output logic [15:0]                       CONTROL_OUTPUT_TERMINAL,
   output logic                              CONTROL_IS_ANALOG,
   output logic                              CONTROL_IS_PULSE,
   output logic                              CONTROL_IS_RELAY,
   output logic [15:0]                       RETRANS_TERMINAL,
   output logic                              RETRANS_B_ON_CONTROL,
   output logic                              LOOP_POWER_EN,
   output contact_io_pkg::contact_out_t      CONTACT_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // Synchronise and debounce each contact
   logic [7:0] sync1_ff;
   logic [7:0] sync2_ff;
   logic [7:0] stable_ff;
   logic [7:0] stable_d_ff;
   logic [7:0] rise;

   always_ff @(posedge REF_CLK)
   begin
      if (!RESETN)
      begin
         sync1_ff <= 8'h00;
         sync2_ff <= 8'h00;
      end
      else
      begin
         sync1_ff <= CONTACT_IN;
         sync2_ff <= sync1_ff;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < contact_io_pkg::NUM_DI; gi++)
      begin : g_db
         logic [10:0] cnt_ff;
         wire         differs = (sync2_ff[gi] != stable_ff[gi]);
         wire         settled = differs && (cnt_ff == contact_io_pkg::DB_CNT_LAST);
         // Level must hold a full window before it is believed
         always_ff @(posedge REF_CLK)
         begin
            if (!RESETN)
            begin
               cnt_ff        <= 11'h000;
               stable_ff[gi] <= 1'b0;
            end
            else
            begin
               cnt_ff        <= (differs && !settled) ? cnt_ff + 11'h001 : 11'h000; // [RULE19]
               stable_ff[gi] <= settled ? sync2_ff[gi] : stable_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge REF_CLK)
   begin
      if (!RESETN)
         stable_d_ff <= 8'h00;
      else
         stable_d_ff <= stable_ff;
   end

   assign rise = stable_ff & ~stable_d_ff; // [RULE19]

   ////////////////////////////////////////////////////////////////////////////
   // Run/stop mode and pattern selection
   typedef enum logic {ST_RESET, ST_RUN} mode_t;
   mode_t      mode_ff;
   mode_t      nxt_mode;
   logic [4:0] pattern_ff;
   wire        start_ev = rise[contact_io_pkg::DI_RUN];
   wire        stop_ev  = rise[contact_io_pkg::DI_STOP] | KEY_STOP;
   wire  [4:0] decoded  = {1'b0, stable_ff[contact_io_pkg::DI_SEL0 +: 4]}; // [RULE1]
   wire  [4:0] nxt_pattern = stable_ff[contact_io_pkg::DI_OFFSET] ?
                             decoded + contact_io_pkg::PATTERN_OFFSET : decoded; // [RULE3]
   wire        in_reset = (mode_ff == ST_RESET);

   // Stop wins when both edges land together, the safe choice
   always_comb
   begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         ST_RESET: if (start_ev && !stop_ev) nxt_mode = ST_RUN; // [RULE4]
         ST_RUN:   if (stop_ev) nxt_mode = ST_RESET;            // [RULE5]
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RESETN)
      begin
         mode_ff    <= ST_RESET;
         pattern_ff <= contact_io_pkg::PATTERN_RESET;
      end
      else
      begin
         mode_ff <= nxt_mode;
         // All-off select leaves the previous pattern in place
         if (in_reset && decoded != 5'h00)
            pattern_ff <= nxt_pattern; // [RULE2]
      end
   end

   assign PATTERN_NUMBER = pattern_ff;
   assign RUNNING        = (mode_ff == ST_RUN);
   assign START_PULSE    = in_reset && nxt_mode == ST_RUN;
   assign STOP_PULSE     = !in_reset && nxt_mode == ST_RESET;

   ////////////////////////////////////////////////////////////////////////////
   // PV source and parameter group
   wire pv_contact_mode = (SWITCH_METHOD_SELECT == contact_io_pkg::SWITCH_CONTACT); // [RULE8]
   wire pv_use2 = pv_contact_mode ? stable_ff[contact_io_pkg::DI_PVSRC] : PV_AUTO_SEL2; // [RULE9]
   wire [15:0] pv_next = pv_use2 ? PV_INPUT2 : PV_INPUT1;

   ////////////////////////////////////////////////////////////////////////////
   // Control and retransmission outputs
   contact_io_pkg::out_type_t otype;
   assign otype = contact_io_pkg::out_type_t'(CONTROL_OUTPUT_TYPE);
   wire [15:0] ctl_next = !RUNNING ? PRESET_OUTPUT_VALUE :            // [RULE6] [RULE7]
                          MANUAL_MODE ? MANUAL_OUTPUT_VALUE : ANALOG_SRC.control;
   wire loop_a  = (AUX_ANALOG_OUT_A_TYPE == contact_io_pkg::RET_LOOP_POWER);
   wire loop_b  = (AUX_ANALOG_OUT_B_TYPE == contact_io_pkg::RET_LOOP_POWER);
   wire loop_on = loop_a | loop_b; // [RULE18]
   wire ret_b_ok = (otype == contact_io_pkg::OUT_RELAY) && !loop_on &&
                   AUX_ANALOG_OUT_B_TYPE != 3'h0; // [RULE16]
   wire [15:0] ret_a_val =
      (AUX_ANALOG_OUT_A_TYPE == contact_io_pkg::RET_SRC_PV)  ? pv_next :
      (AUX_ANALOG_OUT_A_TYPE == contact_io_pkg::RET_SRC_SP)  ? ANALOG_SRC.setpoint :
      (AUX_ANALOG_OUT_A_TYPE == contact_io_pkg::RET_SRC_OUT) ? ctl_next :
      contact_io_pkg::DATA_RESET; // [RULE15]
   // Loop supply owns the terminal, so retransmission is silenced
   wire [15:0] ret_next = loop_on ? contact_io_pkg::DATA_RESET : ret_a_val; // [RULE17]
   wire [15:0] ret_b_val =
      (AUX_ANALOG_OUT_B_TYPE == contact_io_pkg::RET_SRC_PV) ? pv_next :
      (AUX_ANALOG_OUT_B_TYPE == contact_io_pkg::RET_SRC_SP) ? ANALOG_SRC.setpoint : ctl_next;
   wire [15:0] term_next = ret_b_ok ? ret_b_val : ctl_next;

   contact_io_pkg::contact_out_t cout_next;
   assign cout_next.pv_event1  = PV_EVENT1;  // [RULE11]
   assign cout_next.pv_event2  = PV_EVENT2;  // [RULE11]
   assign cout_next.alarm      = ALARM1;     // [RULE12]
   assign cout_next.time_event = TIME_EVENT; // [RULE13]

   logic [15:0]                  pv_ff;
   logic [15:0]                  pid_ff;
   logic [15:0]                  term_ff;
   logic [15:0]                  ret_ff;
   contact_io_pkg::contact_out_t cout_ff;

   always_ff @(posedge REF_CLK)
   begin
      if (!RESETN)
      begin
         pv_ff   <= contact_io_pkg::DATA_RESET;
         pid_ff  <= contact_io_pkg::DATA_RESET;
         term_ff <= contact_io_pkg::DATA_RESET;
         ret_ff  <= contact_io_pkg::DATA_RESET;
         cout_ff <= '0;
      end
      else
      begin
         pv_ff   <= pv_next;
         pid_ff  <= PID_GROUP_PARAM[PID_GROUP_SEL]; // [RULE10]
         term_ff <= term_next;
         ret_ff  <= ret_next;
         cout_ff <= cout_next;
      end
   end

   assign PV_SELECTED             = pv_ff;
   assign ACTIVE_PID_PARAM        = pid_ff;
   assign CONTROL_OUTPUT_TERMINAL = term_ff;
   assign RETRANS_TERMINAL        = ret_ff;
   assign CONTACT_OUT             = cout_ff;
   assign CONTROL_IS_ANALOG       = (otype == contact_io_pkg::OUT_CURRENT); // [RULE14]
   assign CONTROL_IS_PULSE        = (otype == contact_io_pkg::OUT_PULSE);   // [RULE14]
   assign CONTROL_IS_RELAY        = (otype == contact_io_pkg::OUT_RELAY);   // [RULE14]
   assign RETRANS_B_ON_CONTROL    = ret_b_ok;
   assign LOOP_POWER_EN           = loop_on;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_run_edge;
      in_reset && start_ev && !stop_ev;
   endsequence

   property p_start;
      @(posedge REF_CLK) disable iff (!RESETN) s_run_edge |=> RUNNING;
   endproperty
   a_start: assert property (p_start) else $error("run edge did not start"); // [RULE4]

   property p_stop;
      @(posedge REF_CLK) disable iff (!RESETN) (RUNNING && stop_ev) |=> !RUNNING;
   endproperty
   a_stop: assert property (p_stop) else $error("stop edge did not halt"); // [RULE5]

   property p_pattern_hold;
      @(posedge REF_CLK) disable iff (!RESETN) RUNNING |=> $stable(PATTERN_NUMBER);
   endproperty
   a_pattern_hold: assert property (p_pattern_hold) else $error("pattern moved in run"); // [RULE2]

   property p_pattern_load;
      @(posedge REF_CLK) disable iff (!RESETN)
         (in_reset && decoded != 5'h00) |=> PATTERN_NUMBER == $past(nxt_pattern);
   endproperty
   a_pattern_load: assert property (p_pattern_load) else $error("pattern not decoded"); // [RULE1]

   property p_preset;
      @(posedge REF_CLK) disable iff (!RESETN)
         (!RUNNING && !ret_b_ok) |=> CONTROL_OUTPUT_TERMINAL == $past(PRESET_OUTPUT_VALUE);
   endproperty
   a_preset: assert property (p_preset) else $error("preset not driven on halt"); // [RULE6]

   property p_pv_contact;
      @(posedge REF_CLK) disable iff (!RESETN)
         pv_contact_mode && stable_ff[contact_io_pkg::DI_PVSRC] |=>
            PV_SELECTED == $past(PV_INPUT2);
   endproperty
   a_pv_contact: assert property (p_pv_contact) else $error("PV input 2 not used"); // [RULE9]

   property p_loop_excl;
      @(posedge REF_CLK) disable iff (!RESETN)
         loop_on [*2] |-> RETRANS_TERMINAL == 16'h0000 && !RETRANS_B_ON_CONTROL;
   endproperty
   a_loop_excl: assert property (p_loop_excl) else $error("retrans active with loop"); // [RULE17]

   property p_contacts;
      @(posedge REF_CLK) disable iff (!RESETN)
         1'b1 |=> CONTACT_OUT.alarm == $past(ALARM1) &&
                  CONTACT_OUT.time_event == $past(TIME_EVENT);
   endproperty
   a_contacts: assert property (p_contacts) else $error("contact outputs misrouted"); // [RULE12]

   property p_single_edge;
      @(posedge REF_CLK) disable iff (!RESETN) start_ev |=> !start_ev;
   endproperty
   a_single_edge: assert property (p_single_edge) else $error("double run edge"); // [RULE19]

   property p_offset;
      @(posedge REF_CLK) disable iff (!RESETN)
         (in_reset && stable_ff[contact_io_pkg::DI_OFFSET] && decoded != 5'h00) |=>
            PATTERN_NUMBER == $past(decoded) + contact_io_pkg::PATTERN_OFFSET;
   endproperty
   a_offset: assert property (p_offset) else $error("offset not added"); // [RULE3]

   property p_pv_events;
      @(posedge REF_CLK) disable iff (!RESETN)
         1'b1 |=> CONTACT_OUT.pv_event1 == $past(PV_EVENT1) &&
                  CONTACT_OUT.pv_event2 == $past(PV_EVENT2);
   endproperty
   a_pv_events: assert property (p_pv_events) else $error("PV events misrouted"); // [RULE11]

   property p_ret_b_relay;
      @(posedge REF_CLK) disable iff (!RESETN)
         RETRANS_B_ON_CONTROL |-> CONTROL_IS_RELAY && !LOOP_POWER_EN;
   endproperty
   a_ret_b_relay: assert property (p_ret_b_relay) else $error("retrans 2 off relay"); // [RULE16]

endmodule : contact_io_mode_control
`default_nettype wire

// ---- verification/field_contact_model.sv ----
// Field contact switches with mechanical chatter on every change
`timescale 1ns/100ps
`default_nettype none
module field_contact_model
#(
   parameter int unsigned BOUNCE = 8
)
(
   // Clock
   input  wire logic       clk,
   // Requested and delivered contact levels
   input  wire logic [7:0] level_req,
   output logic      [7:0] contact_level
);
   logic [7:0] settled_ff = 8'h00;
   logic [7:0] moved_ff   = 8'h00;
   logic [4:0] chatter_ff = 5'h00;
   ////////////////////////////////////////////////////////////////////////////
   // Real contacts chatter, so only the moved bits toggle for a while
   always @(posedge clk)
   begin
      if (level_req != settled_ff)
      begin
         settled_ff <= level_req;
         moved_ff   <= level_req ^ settled_ff;
         chatter_ff <= 5'(BOUNCE);
      end
      else if (chatter_ff != 5'h00)
         chatter_ff <= chatter_ff - 5'h01;
   end
   assign contact_level = settled_ff ^ (chatter_ff[0] ? moved_ff : 8'h00);
endmodule : field_contact_model
`default_nettype wire

// ---- verification/contact_io_mode_control_test.sv ----
// Self-checking bench for contact decode, run/stop and output routing
`timescale 1ns/100ps
`default_nettype none
module contact_io_mode_control_test;
   logic                        ref_clk = 1'b0;
   logic                        resetn  = 1'b0;
   logic [7:0]                  level_req = 8'h00;
   logic [7:0]                  contact_in;
   logic [1:0]                  method = 2'h0, out_type = 2'h0;
   logic [2:0]                  type_a = 3'h0, type_b = 3'h0, grp = 3'h0;
   logic [15:0]                 preset = 16'h0C80, manual = 16'h1234;
   logic [15:0]                 pid_param [8];
   logic [15:0]                 pv1 = 16'h0111, pv2 = 16'h0222;
   logic                        auto2 = 1'b0, man_mode = 1'b1, key_stop = 1'b0;
   logic [6:0]                  ev = 7'h00;
   contact_io_pkg::analog_src_t src = '{16'h0000, 16'h0345, 16'h0456};
   logic [4:0]                  pattern;
   logic                        running, start_p, stop_p, is_an, is_pu, is_re, b_on, lp_en;
   logic [15:0]                 pv_sel, pid_act, ctrl_term, ret_term;
   contact_io_pkg::contact_out_t c_out;
   int                          errors = 0, cmp_count = 0, starts = 0, stops = 0;
   ////////////////////////////////////////////////////////////////////////////
   initial forever #5 ref_clk = ~ref_clk;
   initial foreach (pid_param[i]) pid_param[i] = 16'h0000;
   // Pulses counted mid-cycle, away from the edge that launches them
   always @(negedge ref_clk) if (start_p === 1'b1) starts++;
   always @(negedge ref_clk) if (stop_p === 1'b1) stops++;
   field_contact_model cm_u (.clk(ref_clk), .level_req(level_req), .contact_level(contact_in));
   contact_io_mode_control dut_u (
      .REF_CLK(ref_clk), .RESETN(resetn), .CONTACT_IN(contact_in),
      .SWITCH_METHOD_SELECT(method), .CONTROL_OUTPUT_TYPE(out_type),
      .AUX_ANALOG_OUT_A_TYPE(type_a), .AUX_ANALOG_OUT_B_TYPE(type_b),
      .PRESET_OUTPUT_VALUE(preset), .PID_GROUP_SEL(grp), .PID_GROUP_PARAM(pid_param),
      .PV_INPUT1(pv1), .PV_INPUT2(pv2), .PV_AUTO_SEL2(auto2), .ANALOG_SRC(src),
      .MANUAL_MODE(man_mode), .MANUAL_OUTPUT_VALUE(manual), .KEY_STOP(key_stop),
      .PV_EVENT1(ev[0]), .PV_EVENT2(ev[1]), .ALARM1(ev[2]), .TIME_EVENT(ev[6:3]),
      .PATTERN_NUMBER(pattern), .RUNNING(running), .START_PULSE(start_p), .STOP_PULSE(stop_p),
      .PV_SELECTED(pv_sel), .ACTIVE_PID_PARAM(pid_act), .CONTROL_OUTPUT_TERMINAL(ctrl_term),
      .CONTROL_IS_ANALOG(is_an), .CONTROL_IS_PULSE(is_pu), .CONTROL_IS_RELAY(is_re),
      .RETRANS_TERMINAL(ret_term), .RETRANS_B_ON_CONTROL(b_on), .LOOP_POWER_EN(lp_en),
      .CONTACT_OUT(c_out));
   ////////////////////////////////////////////////////////////////////////////
   task cmp_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_bit
   task cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_word
   // Debounce is 2000 cycles; margin covers chatter and synchroniser
   task set_contacts(input logic [7:0] v);
      @(posedge ref_clk) level_req <= v;
      repeat (2100) @(posedge ref_clk);
   endtask : set_contacts
   task wait3;
      repeat (3) @(posedge ref_clk);
   endtask : wait3
   task finish_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      errors++;
      finish_test();
   end
   initial
   begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      wait3();
      cmp_word("pattern", 16'h0001, {11'h000, pattern});
      cmp_bit("running", 1'b0, running);
      set_contacts(8'h0B);
      cmp_word("pattern", 16'h000B, {11'h000, pattern});
      set_contacts(8'h83);
      cmp_word("pattern", 16'h0013, {11'h000, pattern});
      cmp_word("ctrl", preset, ctrl_term);
      $display("Test pattern select done");
      set_contacts(8'h93);
      cmp_bit("running", 1'b1, running);
      cmp_word("starts", 16'h0001, 16'(starts));
      cmp_word("ctrl", manual, ctrl_term);
      set_contacts(8'h95);
      cmp_word("pattern", 16'h0013, {11'h000, pattern});
      set_contacts(8'hB5);
      cmp_bit("running", 1'b0, running);
      cmp_word("pattern", 16'h0015, {11'h000, pattern});
      cmp_word("ctrl", preset, ctrl_term);
      set_contacts(8'h85);
      @(posedge ref_clk) level_req <= 8'h95;
      repeat (500) @(posedge ref_clk);
      set_contacts(8'h85);
      cmp_bit("running", 1'b0, running);
      cmp_word("starts", 16'h0001, 16'(starts));
      set_contacts(8'h95);
      cmp_bit("running", 1'b1, running);
      @(posedge ref_clk) man_mode <= 1'b0;
      wait3();
      cmp_word("ctrl", src.control, ctrl_term);
      @(posedge ref_clk) key_stop <= 1'b1;
      @(posedge ref_clk) key_stop <= 1'b0;
      wait3();
      cmp_bit("running", 1'b0, running);
      cmp_word("ctrl", preset, ctrl_term);
      cmp_word("stops", 16'h0002, 16'(stops));
      $display("Test run stop done");
      @(posedge ref_clk) method <= 2'h2;
      wait3();
      cmp_word("pv", pv1, pv_sel);
      set_contacts(8'hC5);
      cmp_word("pv", pv2, pv_sel);
      @(posedge ref_clk) method <= 2'h0;
      wait3();
      cmp_word("pv", pv1, pv_sel);
      @(posedge ref_clk) auto2 <= 1'b1;
      wait3();
      cmp_word("pv", pv2, pv_sel);
      $display("Test pv switch done");
      for (int i = 0; i < 7; i++)
      begin
         @(posedge ref_clk) ev <= 7'(1 << i);
         wait3();
         cmp_word("contact out", 16'(1 << i), {9'h000, c_out});
      end
      for (int g = 0; g < 8; g++)
      begin
         @(posedge ref_clk) pid_param[g] <= 16'hA000 + 16'(g);
         grp <= 3'(g);
         wait3();
         cmp_word("pid", 16'hA000 + 16'(g), pid_act);
      end
      for (int t = 0; t < 3; t++)
      begin
         @(posedge ref_clk) out_type <= 2'(t);
         wait3();
         cmp_word("type", 16'(1 << t), {13'h0000, is_re, is_pu, is_an});
      end
      $display("Test outputs done");
      for (int a = 1; a < 4; a++)
      begin
         @(posedge ref_clk) type_a <= 3'(a);
         wait3();
         cmp_word("retrans", a == 1 ? pv2 : a == 2 ? src.setpoint : preset, ret_term);
      end
      @(posedge ref_clk) type_a <= 3'h4;
      wait3();
      cmp_bit("loop power", 1'b1, lp_en);
      cmp_word("retrans", 16'h0000, ret_term);
      @(posedge ref_clk) type_a <= 3'h0;
      type_b <= 3'h1;
      wait3();
      cmp_bit("loop power", 1'b0, lp_en);
      cmp_bit("b on ctrl", 1'b1, b_on);
      cmp_word("ctrl", pv2, ctrl_term);
      @(posedge ref_clk) out_type <= 2'h0;
      wait3();
      cmp_bit("b on ctrl", 1'b0, b_on);
      @(posedge ref_clk) out_type <= 2'h2;
      type_b <= 3'h4;
      wait3();
      cmp_bit("b on ctrl", 1'b0, b_on);
      cmp_bit("loop power", 1'b1, lp_en);
      $display("Test retransmission done");
      finish_test();
   end
endmodule : contact_io_mode_control_test
`default_nettype wire
